/* File: design/cmpa_regs.vh */
// Constants for the core memory port arbiter
`ifndef CMPA_REGS_VH
`define CMPA_REGS_VH
`define CMPA_NPORTS      4
`define CMPA_ADDR_W      16
`define CMPA_DATA_W      17
`define CMPA_PAR_BIT     16
`define CMPA_DEPTH       65536
`define CMPA_PORT_CPU    2'h0
`define CMPA_GNT_NONE    4'h0
`define CMPA_WORD_W      16
`define CMPA_CNT_RST     8'h00
`define CMPA_CNT_STEP    8'h01
`define CMPA_WORD_RST    16'h0000
`define CMPA_MEMW_RST    17'h0_0000
`define CMPA_BIT_RST     1'h0
`define CMPA_CYC_NS      1000
`define CMPA_CLK_NS      20
`define CMPA_CYC_CNT     ((`CMPA_CYC_NS + `CMPA_CLK_NS - 1) / `CMPA_CLK_NS)
`endif

/* File: design/cmpa_core_mem.v */
// Core memory block storing 16 data bits plus parity per word
`timescale 1ns/1ps
`include "cmpa_regs.vh"
module cmpa_core_mem (
	// Clock
	input  wire                      sys_clk,
	// Access
	input  wire                      we,
	input  wire [`CMPA_ADDR_W-1:0]   addr,
	input  wire [`CMPA_DATA_W-1:0]   wdata,
	output reg  [`CMPA_DATA_W-1:0]   rdata_reg
);
	reg [`CMPA_DATA_W-1:0] mem [0:`CMPA_DEPTH-1];

	// Registered read, old word returned on a write
	always @(posedge sys_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata_reg <= mem[addr];
	end
endmodule

/* File: design/cmpa_arbiter.v */
// Four-port fixed-priority access controller for one core memory block
//
// Summary of operation
// RL1: One controller per block, four requester ports.
// RL2: Fixed wired priority resolves simultaneous requests.
// RL3: Processor port has the lowest priority.
// RL4: Three data channel ports share the block.
// RL5: Each channel transfer steals one memory cycle.
// RL6: Words carry 16 data bits plus parity.
// RL7: Requesters complete accesses by request/acknowledge handshake.
// RL8: Full 16-bit word address supported.
// RL9: Ports may serve several processors.
// RL10: One grant per cycle, held until done.
`timescale 1ns/1ps
`include "cmpa_regs.vh"
module cmpa_arbiter (
	// Clock and reset
	input  wire                          sys_clk,
	input  wire                          srst,
	// Port requests: index 0 processor, 1..3 data channels
	input  wire [`CMPA_NPORTS-1:0]       req,
	input  wire [`CMPA_NPORTS-1:0]       wr,
	input  wire [`CMPA_NPORTS*16-1:0]    addr,
	input  wire [`CMPA_NPORTS*16-1:0]    wdata,
	// Port answers
	output reg  [`CMPA_NPORTS-1:0]       ack_reg,
	output reg  [15:0]                   rdata_reg,
	output reg                           rpar_err_reg,
	output reg  [`CMPA_NPORTS-1:0]       grant_reg
);
	localparam ST_IDLE = 2'b00;
	localparam ST_CYC  = 2'b01;
	localparam ST_DONE = 2'b10;
	localparam integer CYC_CNT_I = `CMPA_CYC_CNT;
	localparam [7:0]   CYC_LAST  = CYC_CNT_I[7:0] - `CMPA_CNT_STEP;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Highest port number wins; processor on port 0 is last
	function [`CMPA_NPORTS-1:0] pick;
		input [`CMPA_NPORTS-1:0] r;
		begin
			if (r[3])
				pick = 4'h8;
			else if (r[2])
				pick = 4'h4;
			else if (r[1])
				pick = 4'h2;
			else if (r[0])
				pick = 4'h1;
			else
				pick = `CMPA_GNT_NONE;
		end
	endfunction

	// Index of a one-hot grant
	function [1:0] idx;
		input [`CMPA_NPORTS-1:0] g;
		begin
			idx = g[3] ? 2'h3 : g[2] ? 2'h2 : g[1] ? 2'h1 : `CMPA_PORT_CPU;
		end
	endfunction

	// Word of one port out of a packed per-port bus
	function [`CMPA_WORD_W-1:0] port_word;
		input [`CMPA_NPORTS*`CMPA_WORD_W-1:0] bus;
		input [1:0]                           p;
		begin
			port_word = bus[p*`CMPA_WORD_W +: `CMPA_WORD_W];
		end
	endfunction

	// Even parity of a data word; stored as the extra bit
	function par_of;
		input [`CMPA_WORD_W-1:0] w;
		begin
			par_of = ^w;
		end
	endfunction

	// ------------------------------------------------------------
	// Input synchronisers (requesters are asynchronous)
	// ------------------------------------------------------------
	reg [`CMPA_NPORTS-1:0] req_s1_reg;
	reg [`CMPA_NPORTS-1:0] req_s2_reg;

	// Two-flop sync of request levels
	always @(posedge sys_clk) begin
		if (srst) begin
			req_s1_reg <= `CMPA_GNT_NONE;
			req_s2_reg <= `CMPA_GNT_NONE;
		end else begin
			req_s1_reg <= req;
			req_s2_reg <= req_s1_reg; // [RL7]
		end
	end

	reg [`CMPA_NPORTS-1:0]              wr_s1_reg;
	reg [`CMPA_NPORTS-1:0]              wr_s2_reg;
	reg [`CMPA_NPORTS*`CMPA_WORD_W-1:0] addr_s1_reg;
	reg [`CMPA_NPORTS*`CMPA_WORD_W-1:0] addr_s2_reg;
	reg [`CMPA_NPORTS*`CMPA_WORD_W-1:0] wdata_s1_reg;
	reg [`CMPA_NPORTS*`CMPA_WORD_W-1:0] wdata_s2_reg;

	// Two-flop sync of write select, address and data
	// Requesters set these before raising the request, so they
	// are settled by the time the synced request is seen
	always @(posedge sys_clk) begin
		wr_s1_reg    <= wr;
		wr_s2_reg    <= wr_s1_reg; // [RL7]
		addr_s1_reg  <= addr;
		addr_s2_reg  <= addr_s1_reg;
		wdata_s1_reg <= wdata;
		wdata_s2_reg <= wdata_s1_reg;
	end

	// ------------------------------------------------------------
	// Cycle state machine
	// ------------------------------------------------------------
	reg  [1:0]               state_reg;
	reg  [1:0]               state_next;
	reg  [7:0]               cnt_reg;
	reg  [1:0]               sel_reg;
	reg                      mem_we_reg;
	reg  [15:0]              mem_addr_reg;
	reg  [16:0]              mem_wdata_reg;
	wire [16:0]              mem_rdata;
	wire [`CMPA_NPORTS-1:0]  win;
	wire [1:0]               win_idx;
	wire                     held_req;
	wire [`CMPA_WORD_W-1:0]  win_word;

	assign win     = pick(req_s2_reg); // [RL2] [RL3] [RL4]
	assign win_idx = idx(win);

	// Request of the port in service, write word of the winner
	assign held_req = req_s2_reg[sel_reg];
	assign win_word = port_word(wdata_s2_reg, win_idx);

	// Grant at the edge after the synced request is seen
	// Ack one memory cycle later, held with the grant
	// Both drop once the synced request of that port falls
	// No other port is looked at until back in idle
	// Next state
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (win != `CMPA_GNT_NONE)
					state_next = ST_CYC;
			end
			ST_CYC: begin
				if (cnt_reg == CYC_LAST)
					state_next = ST_DONE; // [RL5]
			end
			ST_DONE: begin
				if (!held_req)
					state_next = ST_IDLE; // [RL7]
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// Grant, memory drive and handshake
	always @(posedge sys_clk) begin
		if (srst) begin
			state_reg     <= ST_IDLE;
			cnt_reg       <= `CMPA_CNT_RST;
			sel_reg       <= `CMPA_PORT_CPU;
			grant_reg     <= `CMPA_GNT_NONE;
			ack_reg       <= `CMPA_GNT_NONE;
			mem_we_reg    <= `CMPA_BIT_RST;
			mem_addr_reg  <= `CMPA_WORD_RST;
			mem_wdata_reg <= `CMPA_MEMW_RST;
			rdata_reg     <= `CMPA_WORD_RST;
			rpar_err_reg  <= `CMPA_BIT_RST;
		end else begin
			state_reg  <= state_next;
			mem_we_reg <= `CMPA_BIT_RST;
			case (state_reg)
				ST_IDLE: begin
					cnt_reg <= `CMPA_CNT_RST;
					if (win != `CMPA_GNT_NONE) begin
						sel_reg       <= win_idx;
						grant_reg     <= win; // [RL10] [RL9]
						mem_addr_reg  <= port_word(addr_s2_reg, win_idx); // [RL8]
						mem_wdata_reg <= {par_of(win_word), win_word}; // [RL6]
						mem_we_reg    <= wr_s2_reg[win_idx];
					end
				end
				ST_CYC: begin
					cnt_reg <= cnt_reg + `CMPA_CNT_STEP;
					if (cnt_reg == CYC_LAST) begin
						rdata_reg    <= mem_rdata[`CMPA_WORD_W-1:0];
						rpar_err_reg <= par_of(mem_rdata[`CMPA_WORD_W-1:0]) ^ mem_rdata[`CMPA_PAR_BIT]; // [RL6]
						ack_reg      <= grant_reg; // [RL7]
					end
				end
				ST_DONE: begin
					if (!held_req) begin
						ack_reg   <= `CMPA_GNT_NONE;
						grant_reg <= `CMPA_GNT_NONE; // [RL10]
					end
				end
				default: begin
					grant_reg <= `CMPA_GNT_NONE;
					ack_reg   <= `CMPA_GNT_NONE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Memory block
	// ------------------------------------------------------------
	// One block behind this controller
	// Written at the first cycle edge, read back registered
	cmpa_core_mem u_mem ( // [RL1]
		.sys_clk   (sys_clk),
		.we        (mem_we_reg),
		.addr      (mem_addr_reg),
		.wdata     (mem_wdata_reg),
		.rdata_reg (mem_rdata)
	);
endmodule

/* File: testbench/cmpa_arb_props.sv */
// Checker for the core memory port arbiter
`timescale 1ns/1ps
module cmpa_arb_props (
	// Watched ports
	input wire       sys_clk,
	input wire       srst,
	input wire [3:0] req,
	input wire [3:0] ack_reg,
	input wire [3:0] grant_reg,
	input wire       rpar_err_reg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	chk_grant_one: assert property ($onehot0(grant_reg)) else $error("two grants");
	chk_ack_granted: assert property ((ack_reg & ~grant_reg) == 4'h0) else $error("stray ack");
	chk_grant_hold: assert property (grant_reg != 4'h0 && ack_reg == 4'h0 |=> $stable(grant_reg))
		else $error("grant moved");
	chk_cycle_len: assert property ($rose(|grant_reg) |-> ##50 ack_reg == grant_reg) else $error("cycle length");
	chk_grant_req: assert property ((grant_reg & ~($past(req, 2) | $past(req, 3) | $past(req, 4))) == 4'h0)
		else $error("grant without request");
	chk_fixed_prio: assert property ($rose(|grant_reg) |->
		($past(req, 3) & $past(req, 4) & ~((grant_reg << 1) - 4'h1)) == 4'h0) else $error("priority");
	chk_par_clean: assert property ($rose(|ack_reg) |-> !rpar_err_reg) else $error("parity");
	chk_ack_release: assert property (ack_reg != 4'h0 && (ack_reg & req) == 4'h0 |-> ##[1:4] ack_reg == 4'h0)
		else $error("ack stuck");
endmodule

/* File: testbench/cmpa_req_model.sv */
// Requester model: processor and data channel handshakes
`timescale 1ns/1ps
module cmpa_req_model (
	// Clock and control
	input  wire       sys_clk,
	input  wire [3:0] go,
	input  wire [3:0] ack_reg,
	// Requests
	output reg  [3:0] req
);
	initial req = 4'h0;
	// Raise on go, hold until acknowledged, then drop
	always @(posedge sys_clk) req <= (req | go) & ~ack_reg;
endmodule

/* File: testbench/tb_top.sv */
// Testbench for the core memory port arbiter
`timescale 1ns/1ps
module tb_top;
	reg         sys_clk = 1'b0;
	reg         srst = 1'b1;
	reg  [3:0]  go = 4'h0;
	reg  [3:0]  wr = 4'h0;
	wire [63:0] wdata = 64'h0000_0000_A5C3_0000;
	wire [63:0] addr = {4{16'hFFFF}};
	wire [3:0]  req;
	wire [3:0]  ack_reg;
	wire [3:0]  grant_reg;
	wire [15:0] rdata_reg;
	wire        rpar_err_reg;
	integer     failures = 0;
	integer     check_count = 0;
	integer     cycles = 0;
	integer     i;
	always #10 sys_clk = ~sys_clk;
	cmpa_arbiter i_dut (.sys_clk(sys_clk), .srst(srst), .req(req), .wr(wr), .addr(addr), .wdata(wdata),
		.ack_reg(ack_reg), .rdata_reg(rdata_reg), .rpar_err_reg(rpar_err_reg), .grant_reg(grant_reg));
	cmpa_req_model i_req (.sys_clk(sys_clk), .go(go), .ack_reg(ack_reg), .req(req));
	task check(input string name, input [15:0] seen, input [15:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("BAD %0s exp %h seen %h", name, exp, seen);
		end
	endtask
	task finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Request ports at a falling edge
	task pulse(input [3:0] v, input [3:0] w);
		@(negedge sys_clk);
		wr = w;
		go = v;
		@(negedge sys_clk);
		go = 4'h0;
	endtask
	// Wait for one acknowledge and judge the answer
	task serve(input [3:0] g, input [15:0] d);
		integer n;
		n = 0;
		while (ack_reg !== g && n < 300) begin
			@(posedge sys_clk);
			#1;
			n = n + 1;
		end
		check("ack wait", {15'h0000, n >= 300}, 16'h0000);
		check("grant", {12'h000, grant_reg}, {12'h000, g});
		check("rdata", rdata_reg, d);
		check("parity", {15'h0000, rpar_err_reg}, 16'h0000);
		while (ack_reg !== 4'h0 && n < 320) begin
			@(posedge sys_clk);
			#1;
			n = n + 1;
		end
		check("release", {12'h000, grant_reg | ack_reg}, 16'h0000);
	endtask
	// Channel writes the top word, processor reads it back
	task t_write_read;
		pulse(4'h2, 4'h2);
		serve(4'h2, 16'hA5C3);
		pulse(4'h1, 4'h0);
		serve(4'h1, 16'hA5C3);
	endtask
	// All four at once: channels first, processor last
	task t_priority;
		pulse(4'hF, 4'h0);
		for (i = 3; i >= 0; i = i - 1) begin
			serve(4'h1 << i, 16'hA5C3);
		end
	endtask
	// Hang guard
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			failures = failures + 1;
			finish_test;
		end
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		srst = 1'b0;
		t_write_read;
		t_priority;
		finish_test;
	end
endmodule
bind cmpa_arbiter cmpa_arb_props i_props (.sys_clk(sys_clk), .srst(srst), .req(req), .ack_reg(ack_reg),
	.grant_reg(grant_reg), .rpar_err_reg(rpar_err_reg));
